/* File: hdl/sleep_wake_watchdog_control.sv */
// power-save sequencing, wake start-up delays, watchdog and low-voltage control
// assumes all inputs synchronous to CLK; RESET_N covers power-on, brown-out and pin resets
`timescale 1ns/1ps

module sleep_wake_watchdog_control
	import sleep_wake_pkg::*;
(
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic CFG_PROGRAMMED,
	input wire logic CFG_WATCHDOG_ENABLE,
	input wire logic [2:0] CFG_PRIMARY_OSC_SELECT,
	input wire logic [4:0] CFG_OSC_MODE,
	input wire logic POR_BOR_FLAG,
	input wire logic LOW_POWER_RC_CLOCK,
	input wire logic CLEAR_WATCHDOG_INSTR,
	input power_save_cmd_s POWER_SAVE_INSTR,
	input wire logic WAKE_IRQ,
	input wire logic RESET_CONTROL_WR,
	input wire logic [RC_W-1:0] RESET_CONTROL_WDATA,
	input wire logic REFERENCE_SETTLED,
	input wire logic BROWNOUT_ENABLE,
	input wire logic CLOCK_SWITCH_ENABLE,
	input wire logic [2:0] CURRENT_OSC_SELECT,
	input wire logic LP_OSC_SLEEP_KEEP,
	input wire logic OSC_STARTUP_DONE,
	input wire logic PLL_LOCK,
	output logic [RC_W-1:0] RESET_CONTROL_RDATA,
	output logic WATCHDOG_RESET,
	output clock_gate_s CLOCK_GATE,
	output logic SYS_CLOCK_HOLD,
	output logic [2:0] OSC_SELECT,
	output logic LOW_POWER_RC_RUN,
	output logic LOWVOLT_DETECT_ON,
	output logic [RC_LVD_W-1:0] LOWVOLT_THRESHOLD,
	output logic BROWNOUT_ON,
	output power_state_e POWER_STATE
);

	power_state_e state_reg;
	power_state_e state_next;
	osc_kind_e hold_kind_reg;
	osc_kind_e wake_kind;
	logic [2:0] wake_sel;
	logic [DELAY_W-1:0] wake_delay;
	logic boot_reg;
	logic cfg_wdt_en_reg;
	logic [2:0] osc_sel_reg;
	logic rc_prev_reg;
	logic rc_rise;
	logic wdt_en;
	logic wdt_ovf;
	logic wake_now;
	logic delay_done;
	logic hold_ok;
	logic wdt_flag_reg;
	logic sw_wdt_reg;
	logic [RC_LVD_W-1:0] lvd_sel_reg;
	logic lvd_en_reg;
	logic ref_ok_reg;
	logic [RC_W-1:0] rc_value;
	logic [RC_W-1:0] rdata_reg;
	logic wdt_reset_reg;
	clock_gate_s gate_reg;
	clock_gate_s gate_next;
	logic hold_out_reg;
	logic rc_run_reg;
	logic lvd_on_reg;
	logic [RC_LVD_W-1:0] lvd_thr_reg;
	logic bor_on_reg;

	// ----------------------------------------
	// configuration capture after reset
	// ----------------------------------------
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			boot_reg <= 1'b0;
		end else begin
			boot_reg <= 1'b1;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			cfg_wdt_en_reg <= WDT_CFG_ERASED;
		end else if (!boot_reg) begin
			cfg_wdt_en_reg <= CFG_PROGRAMMED ? CFG_WATCHDOG_ENABLE : WDT_CFG_ERASED;
		end
	end

	// ----------------------------------------
	// watchdog
	// ----------------------------------------
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			rc_prev_reg <= 1'b0;
		end else begin
			rc_prev_reg <= LOW_POWER_RC_CLOCK;
		end
	end

	assign rc_rise = LOW_POWER_RC_CLOCK && !rc_prev_reg;
	assign wdt_en = cfg_wdt_en_reg || sw_wdt_reg;

	watchdog_counter u_watchdog (
		.clk(CLK),
		.reset_n(RESET_N),
		.rc_rise(rc_rise),
		.enable(wdt_en),
		.clear(CLEAR_WATCHDOG_INSTR),
		.count(),
		.overflow(wdt_ovf)
	);

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			wdt_reset_reg <= 1'b0;
		end else begin
			wdt_reset_reg <= wdt_ovf && state_reg != ST_SLEEP;
		end
	end

	// ----------------------------------------
	// wake clock choice and delay
	// ----------------------------------------
	always_comb begin
		wake_sel = CLOCK_SWITCH_ENABLE ? CURRENT_OSC_SELECT : osc_sel_reg;
		wake_kind = osc_kind(wake_sel, CFG_OSC_MODE, LP_OSC_SLEEP_KEEP);
		wake_delay = POWER_ON_CYC;
		if (wake_kind == KIND_CRYSTAL) begin
			wake_delay = POWER_ON_CYC + POWER_UP_CYC;
		end else if (wake_kind == KIND_PLL) begin
			wake_delay = POWER_ON_CYC + PLL_LOCK_CYC + POWER_UP_CYC;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			osc_sel_reg <= OSC_SEL_FAST_RC;
		end else if (!boot_reg) begin
			osc_sel_reg <= POR_BOR_FLAG ? CFG_PRIMARY_OSC_SELECT : CURRENT_OSC_SELECT;
		end else if (wake_now) begin
			osc_sel_reg <= wake_sel;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			hold_kind_reg <= KIND_FAST;
		end else if (wake_now) begin
			hold_kind_reg <= wake_kind;
		end
	end

	wake_delay_timer u_wake_delay (
		.clk(CLK),
		.reset_n(RESET_N),
		.load(wake_now),
		.load_value(wake_delay),
		.done(delay_done)
	);

	assign wake_now = state_reg == ST_SLEEP && (WAKE_IRQ || wdt_ovf);
	assign hold_ok = hold_kind_reg == KIND_PLL ? PLL_LOCK : OSC_STARTUP_DONE;

	// ----------------------------------------
	// power state machine
	// ----------------------------------------
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_RUN: begin
				if (POWER_SAVE_INSTR.valid) begin
					state_next = POWER_SAVE_INSTR.sleep ? ST_SLEEP : ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (WAKE_IRQ) begin
					state_next = ST_RUN;
				end
			end
			ST_SLEEP: begin
				if (wake_now) begin
					state_next = ST_WAKE_DELAY;
				end
			end
			ST_WAKE_DELAY: begin
				if (delay_done) begin
					state_next = hold_kind_reg == KIND_FAST ? ST_RUN : ST_WAKE_HOLD;
				end
			end
			ST_WAKE_HOLD: begin
				if (hold_ok) begin
					state_next = ST_RUN;
				end
			end
			default: begin
				state_next = ST_RUN;
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			state_reg <= ST_RUN;
		end else begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------
	// reset-control register
	// ----------------------------------------
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			wdt_flag_reg <= RC_WDT_FLAG_RST;
		end else if (state_reg == ST_SLEEP && wdt_ovf) begin
			wdt_flag_reg <= 1'b0;
		end else if (RESET_CONTROL_WR) begin
			wdt_flag_reg <= RESET_CONTROL_WDATA[RC_WDT_FLAG_BIT];
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			sw_wdt_reg <= RC_SW_WDT_RST;
			lvd_sel_reg <= RC_LVD_RST;
			lvd_en_reg <= RC_LVD_EN_RST;
		end else if (RESET_CONTROL_WR) begin
			sw_wdt_reg <= RESET_CONTROL_WDATA[RC_SW_WDT_BIT];
			lvd_sel_reg <= RESET_CONTROL_WDATA[RC_LVD_LSB +: RC_LVD_W];
			lvd_en_reg <= RESET_CONTROL_WDATA[RC_LVD_EN_BIT];
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			ref_ok_reg <= 1'b0;
		end else begin
			ref_ok_reg <= lvd_en_reg && REFERENCE_SETTLED;
		end
	end

	always_comb begin
		rc_value = '0;
		rc_value[RC_WDT_FLAG_BIT] = wdt_flag_reg;
		rc_value[RC_SW_WDT_BIT] = sw_wdt_reg;
		rc_value[RC_LVD_LSB +: RC_LVD_W] = lvd_sel_reg;
		rc_value[RC_LVD_EN_BIT] = lvd_en_reg;
		rc_value[RC_REF_OK_BIT] = ref_ok_reg;
	end

	// ----------------------------------------
	// registered outputs
	// ----------------------------------------
	always_comb begin
		gate_next.cpu = state_next == ST_RUN;
		gate_next.periph = state_next == ST_RUN || state_next == ST_IDLE;
		gate_next.osc = state_next != ST_SLEEP || LP_OSC_SLEEP_KEEP;
		gate_next.fail_safe = state_next != ST_SLEEP;
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			gate_reg <= '0;
			hold_out_reg <= 1'b0;
		end else begin
			gate_reg <= gate_next;
			hold_out_reg <= state_next == ST_WAKE_DELAY || state_next == ST_WAKE_HOLD;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			rdata_reg <= '0;
			rc_run_reg <= 1'b0;
			lvd_on_reg <= 1'b0;
			lvd_thr_reg <= RC_LVD_RST;
			bor_on_reg <= 1'b0;
		end else begin
			rdata_reg <= rc_value;
			rc_run_reg <= wdt_en;
			lvd_on_reg <= lvd_en_reg;
			lvd_thr_reg <= lvd_sel_reg;
			bor_on_reg <= BROWNOUT_ENABLE;
		end
	end

	assign RESET_CONTROL_RDATA = rdata_reg;
	assign WATCHDOG_RESET = wdt_reset_reg;
	assign CLOCK_GATE = gate_reg;
	assign SYS_CLOCK_HOLD = hold_out_reg;
	assign OSC_SELECT = osc_sel_reg;
	assign LOW_POWER_RC_RUN = rc_run_reg;
	assign LOWVOLT_DETECT_ON = lvd_on_reg;
	assign LOWVOLT_THRESHOLD = lvd_thr_reg;
	assign BROWNOUT_ON = bor_on_reg;
	assign POWER_STATE = state_reg;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	wdt_reset_pulse_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		(wdt_ovf && state_reg != ST_SLEEP) |=> WATCHDOG_RESET ##1 !WATCHDOG_RESET)
		else $error("watchdog overflow did not pulse reset");

	sleep_wdt_wake_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		(state_reg == ST_SLEEP && wdt_ovf) |=> state_reg == ST_WAKE_DELAY && !wdt_flag_reg
			&& !WATCHDOG_RESET)
		else $error("sleep overflow did not wake with flag cleared");

	idle_sleep_entry_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		(state_reg == ST_RUN && POWER_SAVE_INSTR.valid) |=>
			state_reg == ($past(POWER_SAVE_INSTR.sleep) ? ST_SLEEP : ST_IDLE))
		else $error("power-save operand not honoured");

	sleep_gating_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		state_reg == ST_SLEEP |-> !CLOCK_GATE.cpu && !CLOCK_GATE.periph
			&& CLOCK_GATE.osc == LP_OSC_SLEEP_KEEP)
		else $error("clocks not gated in sleep");

	fail_safe_off_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		state_reg == ST_SLEEP |-> !CLOCK_GATE.fail_safe)
		else $error("fail-safe monitor active in sleep");

	lvd_enable_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		RESET_CONTROL_WR |=> ##1 LOWVOLT_DETECT_ON == $past(RESET_CONTROL_WDATA[RC_LVD_EN_BIT], 2))
		else $error("low-voltage detector enable not followed");

	pll_hold_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		(state_reg == ST_WAKE_HOLD && hold_kind_reg == KIND_PLL && !PLL_LOCK) |=>
			state_reg == ST_WAKE_HOLD && SYS_CLOCK_HOLD && !CLOCK_GATE.cpu)
		else $error("clock released before pll lock");

endmodule : sleep_wake_watchdog_control

/* File: hdl/wake_delay_timer.sv */
// down-counter that times the start-up delay after a wake
// assumes load_value is at least one
`timescale 1ns/1ps

module wake_delay_timer
	import sleep_wake_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic load,
	input wire logic [DELAY_W-1:0] load_value,
	output logic done
);

	logic [DELAY_W-1:0] count_reg;
	logic [DELAY_W-1:0] elapsed_reg;
	logic [DELAY_W-1:0] loaded_reg;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			count_reg <= '0;
		end else if (load) begin
			count_reg <= load_value;
		end else if (count_reg != '0) begin
			count_reg <= count_reg - 1'b1;
		end
	end

	assign done = !load && count_reg == DELAY_W'(1);

	// ----------------------------------------
	// helper for the length check
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!reset_n || load) begin
			elapsed_reg <= '0;
			loaded_reg <= load ? load_value : '0;
		end else begin
			elapsed_reg <= elapsed_reg + 1'b1;
		end
	end

	delay_length_a: assert property (@(posedge clk) disable iff (!reset_n)
		done |-> DELAY_W'(elapsed_reg + 1'b1) == loaded_reg)
		else $error("wake delay length wrong");

endmodule : wake_delay_timer

/* File: hdl/watchdog_counter.sv */
// watchdog count driven by low-power RC clock edges
// assumes rc_rise is a one-cycle pulse per RC clock rising edge
`timescale 1ns/1ps

module watchdog_counter
	import sleep_wake_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic rc_rise,
	input wire logic enable,
	input wire logic clear,
	output logic [WDT_W-1:0] count,
	output logic overflow
);

	logic [WDT_W-1:0] count_reg;
	logic overflow_reg;

	// ----------------------------------------
	// count and overflow
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!reset_n || clear) begin
			count_reg <= '0;
		end else if (enable && rc_rise) begin
			count_reg <= count_reg + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			overflow_reg <= 1'b0;
		end else begin
			overflow_reg <= enable && rc_rise && !clear && count_reg == WDT_MAX;
		end
	end

	assign count = count_reg;
	assign overflow = overflow_reg;

	wrap_to_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
		overflow |-> count_reg == '0)
		else $error("watchdog count not zero after overflow");

	clear_holds_a: assert property (@(posedge clk) disable iff (!reset_n)
		clear |=> !overflow ##1 count_reg <= WDT_W'(2))
		else $error("watchdog not restarted by clear");

endmodule : watchdog_counter

/* File: shared/sleep_wake_pkg.sv */
// constants, types and helpers shared by the sleep, wake and watchdog block
// assumes a single 100 MHz system clock and synchronous inputs
//
// Function
// - watchdog counts low-power RC clock edges, independent of gated system clocks
// - configuration watchdog-enable bit at 1 enables the watchdog unconditionally
// - erased configuration reads watchdog enable as 1
// - enabled watchdog counts to overflow; overflow resets device unless sleeping
// - clear-watchdog instruction restarts the watchdog count from zero
// - overflow in sleep wakes the device and clears the timeout flag
// - with configuration enable 0, software enable bit 5 runs the watchdog
// - bits 11 to 8 select the low-voltage trip threshold
// - bit 13 is set once the voltage reference has settled while bit 12 is set
// - low-voltage detector runs only while bit 12 is set
// - power-save instruction operand chooses idle or sleep
// - sleep gates cpu and peripheral clocks and stops on-chip oscillator unless LP_OSC_SLEEP_KEEP is set
// - fail-safe monitor off in sleep; RC clock runs while watchdog runs
// - brown-out and low-voltage detection keep running in sleep
// - sleep ends on enabled interrupt, any reset, or watchdog overflow
// - wake restarts previous clock; with switching, current selection decides
// - after power-on or brown-out, oscillator comes from configuration fields
// - crystal wake waits start-up timer, pll waits lock, plus delays
// - fast clock sources wake after power-on delay only
// - low-power crystal kept in sleep wakes after power-on delay only

package sleep_wake_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int POWER_ON_DELAY_NS = 10000;
	localparam int PLL_LOCK_DELAY_NS = 20000;
	localparam int POWER_UP_TIMER_DELAY_NS = 16000;
	localparam int DELAY_W = 13;
	localparam logic [DELAY_W-1:0] POWER_ON_CYC =
		DELAY_W'((POWER_ON_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [DELAY_W-1:0] PLL_LOCK_CYC =
		DELAY_W'((PLL_LOCK_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [DELAY_W-1:0] POWER_UP_CYC =
		DELAY_W'((POWER_UP_TIMER_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// ----------------------------------------
	// watchdog
	// ----------------------------------------
	localparam int WDT_W = 8;
	localparam logic [WDT_W-1:0] WDT_MAX = 8'hFF;
	localparam logic WDT_CFG_ERASED = 1'b1;

	// ----------------------------------------
	// reset-control register layout
	// ----------------------------------------
	localparam int RC_W = 16;
	localparam int RC_WDT_FLAG_BIT = 4;
	localparam int RC_SW_WDT_BIT = 5;
	localparam int RC_LVD_LSB = 8;
	localparam int RC_LVD_W = 4;
	localparam int RC_LVD_EN_BIT = 12;
	localparam int RC_REF_OK_BIT = 13;
	localparam logic RC_WDT_FLAG_RST = 1'b1;
	localparam logic RC_SW_WDT_RST = 1'b0;
	localparam logic [RC_LVD_W-1:0] RC_LVD_RST = 4'h0;
	localparam logic RC_LVD_EN_RST = 1'b0;

	// ----------------------------------------
	// oscillator selection and mode codes
	// ----------------------------------------
	localparam logic [2:0] OSC_SEL_FAST_RC = 3'h0;
	localparam logic [2:0] OSC_SEL_LP_CRYSTAL = 3'h1;
	localparam logic [2:0] OSC_SEL_LOW_POWER_RC = 3'h2;
	localparam logic [2:0] OSC_SEL_PRIMARY = 3'h3;
	localparam logic [1:0] MODE_EXT_CLOCK = 2'h0;
	localparam logic [1:0] MODE_EXT_RC = 2'h1;
	localparam logic [1:0] MODE_CRYSTAL = 2'h2;
	localparam logic [1:0] MODE_CRYSTAL_PLL = 2'h3;

	typedef enum logic [1:0] {
		KIND_FAST = 2'h0,
		KIND_CRYSTAL = 2'h1,
		KIND_PLL = 2'h2
	} osc_kind_e;

	typedef enum logic [4:0] {
		ST_RUN = 5'h01,
		ST_IDLE = 5'h02,
		ST_SLEEP = 5'h04,
		ST_WAKE_DELAY = 5'h08,
		ST_WAKE_HOLD = 5'h10
	} power_state_e;

	typedef struct packed {
		logic valid;
		logic sleep;
	} power_save_cmd_s;

	typedef struct packed {
		logic cpu;
		logic periph;
		logic osc;
		logic fail_safe;
	} clock_gate_s;

	// classify the wake clock: what start-up it needs
	function automatic osc_kind_e osc_kind(input logic [2:0] sel, input logic [4:0] mode,
		input logic keep);
		osc_kind_e k;
		k = KIND_FAST;
		if (sel == OSC_SEL_LP_CRYSTAL) begin
			k = keep ? KIND_FAST : KIND_CRYSTAL;
		end else if (sel == OSC_SEL_PRIMARY && mode[1:0] == MODE_CRYSTAL) begin
			k = KIND_CRYSTAL;
		end else if (sel == OSC_SEL_PRIMARY && mode[1:0] == MODE_CRYSTAL_PLL) begin
			k = KIND_PLL;
		end
		return k;
	endfunction : osc_kind

endpackage : sleep_wake_pkg

/* File: tb/tb_top.sv */
// self-checking bench for the sleep, wake and watchdog block
// assumes the package and design files are compiled first; the bench drives every port
`timescale 1ns/1ps

module tb_top;
	import sleep_wake_pkg::*;

	typedef struct {
		logic [4:0] st;
		int at;
	} note_t;
	typedef struct {
		logic [2:0] sel;
		logic [4:0] mode;
		logic keep;
		logic cs;
		logic [2:0] cur;
		int dly;
		int hold;
	} case_t;

	// ----------------------------------------
	// stimulus and scoreboard state
	// ----------------------------------------
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic prog = 1'b1;
	logic cfg_en = 1'b0;
	logic [2:0] sel = 3'h0;
	logic [4:0] mode = 5'h00;
	logic rc = 1'b0;
	logic clr = 1'b0;
	power_save_cmd_s ps = '0;
	logic irq = 1'b0;
	logic wr = 1'b0;
	logic [15:0] wd = 16'h0000;
	logic settled = 1'b0;
	logic bo_en = 1'b0;
	logic cs = 1'b0;
	logic [2:0] cur = 3'h0;
	logic keep = 1'b0;
	logic osc_done = 1'b0;
	logic lock = 1'b0;
	logic por = 1'b1;
	logic [15:0] rdata;
	logic wdt_rst;
	clock_gate_s gate;
	logic hold;
	logic [2:0] osc;
	logic rc_run;
	logic lvd_on;
	logic [3:0] lvd_lvl;
	logic bo_on;
	power_state_e state;
	note_t st_q[$];
	int wdt_q[$];
	int cyc = 0;
	int error_cnt = 0;
	int checks_done = 0;
	logic [4:0] last_st = 5'h01;
	logic [15:0] rnd = 16'h003B;
	logic [15:0] img = 16'h0000;
	// sel, mode, keep, switch, current, wake delay, hold kind
	case_t cases[10] = '{
		'{3'h0, 5'h00, 1'b0, 1'b0, 3'h1, 1000, 0},
		'{3'h2, 5'h00, 1'b0, 1'b0, 3'h1, 1000, 0},
		'{3'h1, 5'h00, 1'b0, 1'b0, 3'h1, 2600, 1},
		'{3'h1, 5'h00, 1'b1, 1'b0, 3'h1, 1000, 0},
		'{3'h3, 5'h00, 1'b0, 1'b0, 3'h1, 1000, 0},
		'{3'h3, 5'h01, 1'b0, 1'b0, 3'h1, 1000, 0},
		'{3'h3, 5'h02, 1'b0, 1'b0, 3'h1, 2600, 1},
		'{3'h3, 5'h03, 1'b0, 1'b0, 3'h1, 4600, 2},
		'{3'h3, 5'h02, 1'b0, 1'b1, 3'h0, 1000, 0},
		'{3'h0, 5'h03, 1'b0, 1'b1, 3'h3, 4600, 2}
	};

	sleep_wake_watchdog_control DUT (
		.CLK(clk), .RESET_N(reset_n), .CFG_PROGRAMMED(prog), .CFG_WATCHDOG_ENABLE(cfg_en),
		.CFG_PRIMARY_OSC_SELECT(sel), .CFG_OSC_MODE(mode), .POR_BOR_FLAG(por), .LOW_POWER_RC_CLOCK(rc),
		.CLEAR_WATCHDOG_INSTR(clr), .POWER_SAVE_INSTR(ps), .WAKE_IRQ(irq), .RESET_CONTROL_WR(wr),
		.RESET_CONTROL_WDATA(wd), .REFERENCE_SETTLED(settled), .BROWNOUT_ENABLE(bo_en),
		.CLOCK_SWITCH_ENABLE(cs), .CURRENT_OSC_SELECT(cur), .LP_OSC_SLEEP_KEEP(keep),
		.OSC_STARTUP_DONE(osc_done), .PLL_LOCK(lock), .RESET_CONTROL_RDATA(rdata), .WATCHDOG_RESET(wdt_rst),
		.CLOCK_GATE(gate), .SYS_CLOCK_HOLD(hold), .OSC_SELECT(osc), .LOW_POWER_RC_RUN(rc_run),
		.LOWVOLT_DETECT_ON(lvd_on), .LOWVOLT_THRESHOLD(lvd_lvl), .BROWNOUT_ON(bo_on), .POWER_STATE(state)
	);

	always #5 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;

	// ----------------------------------------
	// compare tasks and helpers
	// ----------------------------------------
	task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp_val

	task automatic cmp_note(input note_t n, input logic [4:0] got);
		checks_done++;
		if (got !== n.st || (n.at >= 0 && cyc != n.at)) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: got %h cycle %h expected %h cycle %h", $time, got, cyc, n.st, n.at);
		end
	endtask : cmp_note

	task automatic wrap_up();
		if (error_cnt == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : wrap_up

	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction : lfsr

	// each state change consumes the oldest note, each watchdog reset pulse the oldest wdt_q entry
	always @(negedge clk) begin
		if (reset_n === 1'b1 && state !== last_st) cmp_note(st_q.size() ? st_q.pop_front() : note_t'{5'h1F, -1}, state);
		last_st = state;
		if (reset_n === 1'b1 && wdt_rst === 1'b1) cmp_val(16'h0001, wdt_q.size() ? 16'(wdt_q.pop_front()) : 16'h0000);
	end

	task automatic do_reset(input logic p, input logic e, input case_t c);
		@(posedge clk);
		reset_n <= 1'b0;
		prog <= p;
		cfg_en <= e;
		sel <= c.sel;
		mode <= c.mode;
		keep <= c.keep;
		cs <= c.cs;
		cur <= c.cur;
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk);
	endtask : do_reset

	task automatic reg_wr(input logic [15:0] d);
		@(posedge clk);
		wr <= 1'b1;
		wd <= d;
		img = d & 16'h1F30;
		@(posedge clk);
		wr <= 1'b0;
	endtask : reg_wr

	task automatic save(input logic s);
		@(posedge clk);
		ps <= '{valid: 1'b1, sleep: s};
		st_q.push_back('{s ? 5'h04 : 5'h02, cyc + 2});
		@(posedge clk);
		ps <= '0;
	endtask : save

	task automatic irq_pulse(input logic [4:0] st, output int t0);
		@(posedge clk);
		irq <= 1'b1;
		t0 = cyc + 2;
		st_q.push_back('{st, t0});
		@(posedge clk);
		irq <= 1'b0;
	endtask : irq_pulse

	task automatic rc_ticks(input int n);
		repeat (n) begin
			@(posedge clk);
			rc <= 1'b1;
			repeat (2) @(posedge clk);
			rc <= 1'b0;
			@(posedge clk);
		end
	endtask : rc_ticks

	// a full count from zero must give exactly one reset pulse
	task automatic wdt_check();
		rc_ticks(255);
		repeat (8) @(posedge clk);
		wdt_q.push_back(1);
		rc_ticks(1);
		repeat (8) @(posedge clk);
		cmp_val(16'(wdt_q.size()), 16'h0000);
	endtask : wdt_check

	task automatic run_case(input case_t c);
		int t0;
		rnd = lfsr(rnd);
		@(posedge clk);
		settled <= rnd[0];
		bo_en <= rnd[1];
		reg_wr(rnd | 16'h2000);
		repeat (3) @(posedge clk);
		cmp_val(rdata, img | {2'b00, img[12] & rnd[0], 13'h0000});
		cmp_val(16'({lvd_on, lvd_lvl, rc_run}), 16'({img[12], img[11:8], img[5]}));
		save(1'b0);
		repeat (3) @(posedge clk);
		cmp_val(16'({gate.cpu, gate.periph}), 16'h0001);
		irq_pulse(5'h01, t0);
		save(1'b1);
		repeat (3) @(posedge clk);
		cmp_val(16'({gate, lvd_on, bo_on, hold}), 16'({2'b00, c.keep, 1'b0, img[12], rnd[1], 1'b0}));
		irq_pulse(5'h08, t0);
		st_q.push_back('{c.hold ? 5'h10 : 5'h01, t0 + c.dly});
		repeat (3) @(posedge clk);
		cmp_val(16'({gate, hold}), 16'h0007);
		repeat (c.dly + 20) @(posedge clk);
		if (c.hold != 0) begin
			cmp_val(16'(hold), 16'h0001);
			osc_done <= (c.hold == 1);
			lock <= (c.hold == 2);
			st_q.push_back('{5'h01, cyc + 2});
			repeat (3) @(posedge clk);
			osc_done <= 1'b0;
			lock <= 1'b0;
		end
		cmp_val(16'({gate, hold, osc}), 16'({5'b11110, c.cs ? c.cur : c.sel}));
		cmp_val(16'(st_q.size()), 16'h0000);
	endtask : run_case

	// ----------------------------------------
	// main sequence and hang guard
	// ----------------------------------------
	initial begin
		for (int i = 0; i < 10; i++) begin
			do_reset(1'b1, 1'b0, cases[i]);
			cmp_val(rdata, 16'h0010);
			cmp_val(16'(osc), 16'(cases[i].sel));
			run_case(cases[i]);
		end
		do_reset(1'b0, 1'b0, cases[0]);
		cmp_val(16'(rc_run), 16'h0001);
		save(1'b1);
		st_q.push_back('{5'h08, -1});
		st_q.push_back('{5'h01, -1});
		rc_ticks(256);
		repeat (1100) @(posedge clk);
		cmp_val(rdata, 16'h0000);
		wdt_check();
		por <= 1'b0;
		do_reset(1'b1, 1'b1, cases[0]);
		cmp_val(16'(rc_run), 16'h0001);
		cmp_val(16'(osc), 16'(cases[0].cur));
		rc_ticks(200);
		@(posedge clk);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		wdt_check();
		do_reset(1'b1, 1'b0, cases[0]);
		rc_ticks(300);
		reg_wr(16'h0020);
		repeat (3) @(posedge clk);
		cmp_val(16'(rc_run), 16'h0001);
		wdt_check();
		cmp_val(16'(st_q.size()), 16'h0000);
		wrap_up();
	end

	initial begin
		#1_000_000;
		error_cnt++;
		wrap_up();
	end

endmodule : tb_top
